/* pkg/qcl_pkg.sv */
// How it works
// - One 32-bit up/down quadrature-fed counter
// - An edge on one phase alone steps (edges on both at once do not); order sets direction
// - Run bit level: 0 stops, 1 runs
// - Writing 1 to zero strobe clears count
// - Writing 1 to capture strobe latches count
// - Strobes self-clear; run bit changes only when written
// - Captured count reads back as full word
// - Registers sit at the basic counter addresses
`default_nettype none
package qcl_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int QCL_COUNT_W = 32;
	localparam int QCL_ADDR_W = 32;
	localparam int QCL_DATA_W = 32;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [31:0] QCL_ADDR_CAPTURED = 32'h20400204;
	localparam logic [31:0] QCL_ADDR_RUN = 32'h20400300;
	localparam logic [31:0] QCL_ADDR_ZERO = 32'h20400310;
	localparam logic [31:0] QCL_ADDR_CAPTURE = 32'h20400320;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int QCL_CTRL_BIT = 0;
	localparam logic [31:0] QCL_COUNT_RESET = 32'h00000000;
	localparam logic [31:0] QCL_CAPTURED_RESET = 32'h00000000;
	localparam logic QCL_RUN_RESET = 1'h0;
	localparam logic [31:0] QCL_COUNT_STEP = 32'h00000001;
	localparam logic [30:0] QCL_UPPER_ZERO = 31'h00000000;

	// ****************************************
	// Bus answers
	// ****************************************
	localparam logic [1:0] QCL_RESP_OKAY = 2'h0;
	localparam logic [1:0] QCL_RESP_SLVERR = 2'h2;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic step;
		logic up;
	} qcl_step_t;

	typedef struct packed {
		logic run;
		logic zero;
		logic capture;
	} qcl_ctrl_t;
endpackage : qcl_pkg
`default_nettype wire

/* core/qcl_quad_decode.sv */
`default_nettype none
module qcl_quad_decode (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic enc_a,
	input wire logic enc_b,
	output var qcl_pkg::qcl_step_t step_q
);
	// ****************************************
	// Pin synchronisers and phase history
	// ****************************************
	logic a_s1_q, a_s2_q, b_s1_q, b_s2_q, a_p_q, b_p_q;
	qcl_pkg::qcl_step_t step_d;

	always_comb begin
		step_d.step = (a_s2_q ^ a_p_q) ^ (b_s2_q ^ b_p_q);
		step_d.up = a_s2_q ^ b_p_q;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			a_s1_q <= 1'h0;
			a_s2_q <= 1'h0;
			b_s1_q <= 1'h0;
			b_s2_q <= 1'h0;
			a_p_q <= 1'h0;
			b_p_q <= 1'h0;
			step_q <= '0;
		end else begin
			a_s1_q <= enc_a;
			a_s2_q <= a_s1_q;
			b_s1_q <= enc_b;
			b_s2_q <= b_s1_q;
			a_p_q <= a_s2_q;
			b_p_q <= b_s2_q;
			step_q <= step_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	single_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		((a_s2_q != a_p_q) != (b_s2_q != b_p_q)) |=> step_q.step)
		else $error("Single phase edge gave no step");
	no_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		((a_s2_q != a_p_q) == (b_s2_q != b_p_q)) |=> !step_q.step)
		else $error("Step without a single phase edge");
	a_leads_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		($rose(a_s2_q) && !b_s2_q && $stable(b_s2_q)) |=> step_q.up)
		else $error("A leading B did not count up");
endmodule // qcl_quad_decode
`default_nettype wire

/* core/qcl_top.sv */
// Decided for this implementation: the AXI4-Lite register port.
`default_nettype none
module qcl_top #(
	parameter int COUNT_W = qcl_pkg::QCL_COUNT_W
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output var logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output var logic s_axi_wready,
	output var logic [1:0] s_axi_bresp,
	output var logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output var logic s_axi_arready,
	output var logic [31:0] s_axi_rdata,
	output var logic [1:0] s_axi_rresp,
	output var logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ****************************************
	// Edge decoder
	// ****************************************
	qcl_pkg::qcl_step_t step;

	qcl_quad_decode u_decode (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.enc_a(enc_a),
		.enc_b(enc_b),
		.step_q(step)
	);

	// ****************************************
	// Write channel state
	// ****************************************
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic aw_held_q, aw_held_d;
	logic w_held_q, w_held_d;
	logic [31:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic w_lane0_q, w_lane0_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic wr_fire;
	logic wr_bit;

	always_comb begin
		awready_d = awready_q;
		wready_d = wready_q;
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		aw_addr_d = aw_addr_q;
		w_data_d = w_data_q;
		w_lane0_d = w_lane0_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		wr_fire = aw_held_q && w_held_q && !bvalid_q;
		wr_bit = w_lane0_q && w_data_q[qcl_pkg::QCL_CTRL_BIT];
		if (s_axi_awvalid && awready_q) begin
			aw_held_d = 1'h1;
			awready_d = 1'h0;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_held_d = 1'h1;
			wready_d = 1'h0;
			w_data_d = s_axi_wdata;
			w_lane0_d = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_held_d = 1'h0;
			w_held_d = 1'h0;
			bvalid_d = 1'h1;
			unique case (aw_addr_q)
				qcl_pkg::QCL_ADDR_CAPTURED,
				qcl_pkg::QCL_ADDR_RUN,
				qcl_pkg::QCL_ADDR_ZERO,
				qcl_pkg::QCL_ADDR_CAPTURE: bresp_d = qcl_pkg::QCL_RESP_OKAY;
				default: bresp_d = qcl_pkg::QCL_RESP_SLVERR;
			endcase
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'h0;
			awready_d = 1'h1;
			wready_d = 1'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			awready_q <= 1'h1;
			wready_q <= 1'h1;
			aw_held_q <= 1'h0;
			w_held_q <= 1'h0;
			aw_addr_q <= 32'h00000000;
			w_data_q <= 32'h00000000;
			w_lane0_q <= 1'h0;
			bvalid_q <= 1'h0;
			bresp_q <= qcl_pkg::QCL_RESP_OKAY;
		end else begin
			awready_q <= awready_d;
			wready_q <= wready_d;
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_lane0_q <= w_lane0_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// ****************************************
	// Control bits and strobes
	// ****************************************
	qcl_pkg::qcl_ctrl_t ctrl_q, ctrl_d;

	always_comb begin
		ctrl_d = ctrl_q;
		ctrl_d.zero = 1'h0;
		ctrl_d.capture = 1'h0;
		if (wr_fire && w_lane0_q) begin
			unique case (aw_addr_q)
				qcl_pkg::QCL_ADDR_RUN: ctrl_d.run = w_data_q[qcl_pkg::QCL_CTRL_BIT];
				qcl_pkg::QCL_ADDR_ZERO: ctrl_d.zero = wr_bit;
				qcl_pkg::QCL_ADDR_CAPTURE: ctrl_d.capture = wr_bit;
				default: ctrl_d.run = ctrl_q.run;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q.run <= qcl_pkg::QCL_RUN_RESET;
			ctrl_q.zero <= 1'h0;
			ctrl_q.capture <= 1'h0;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ****************************************
	// Counter and capture latch
	// ****************************************
	logic [COUNT_W-1:0] count_q, count_d;
	logic [COUNT_W-1:0] captured_q, captured_d;

	always_comb begin
		count_d = count_q;
		captured_d = captured_q;
		if (ctrl_q.capture) begin
			captured_d = count_q;
		end
		if (ctrl_q.zero) begin
			count_d = qcl_pkg::QCL_COUNT_RESET[COUNT_W-1:0];
		end else if (ctrl_q.run && step.step) begin
			if (step.up) begin
				count_d = count_q + qcl_pkg::QCL_COUNT_STEP[COUNT_W-1:0];
			end else begin
				count_d = count_q - qcl_pkg::QCL_COUNT_STEP[COUNT_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= qcl_pkg::QCL_COUNT_RESET[COUNT_W-1:0];
			captured_q <= qcl_pkg::QCL_CAPTURED_RESET[COUNT_W-1:0];
		end else begin
			count_q <= count_d;
			captured_q <= captured_d;
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	logic arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	always_comb begin
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'h0;
			rvalid_d = 1'h1;
			rresp_d = qcl_pkg::QCL_RESP_OKAY;
			unique case (s_axi_araddr)
				qcl_pkg::QCL_ADDR_CAPTURED: rdata_d = 32'(captured_q);
				qcl_pkg::QCL_ADDR_RUN: rdata_d = {qcl_pkg::QCL_UPPER_ZERO, ctrl_q.run};
				qcl_pkg::QCL_ADDR_ZERO: rdata_d = {qcl_pkg::QCL_UPPER_ZERO, ctrl_q.zero};
				qcl_pkg::QCL_ADDR_CAPTURE: rdata_d = {qcl_pkg::QCL_UPPER_ZERO, ctrl_q.capture};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = qcl_pkg::QCL_RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'h0;
			arready_d = 1'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			arready_q <= 1'h1;
			rvalid_q <= 1'h0;
			rdata_q <= 32'h00000000;
			rresp_q <= qcl_pkg::QCL_RESP_OKAY;
		end else begin
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// ****************************************
	// Checks
	// ****************************************
	sequence zero_write_s;
		wr_fire && w_lane0_q && w_data_q[0] && (aw_addr_q == qcl_pkg::QCL_ADDR_ZERO);
	endsequence

	sequence capture_write_s;
		wr_fire && w_lane0_q && w_data_q[0] && (aw_addr_q == qcl_pkg::QCL_ADDR_CAPTURE);
	endsequence

	clear_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		zero_write_s |=> ctrl_q.zero ##1 (count_q == '0))
		else $error("Zero strobe did not clear count");
	capture_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		capture_write_s |=> ctrl_q.capture ##1 (captured_q == $past(count_q)))
		else $error("Capture strobe did not latch count");
	run_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!ctrl_q.run && !ctrl_q.zero) |=> (count_q == $past(count_q)))
		else $error("Count moved while stopped");
	step_up_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(ctrl_q.run && !ctrl_q.zero && step.step && step.up) |=> (count_q == $past(count_q) + 32'h1))
		else $error("Up step not counted");
	wrap_down_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(ctrl_q.run && !ctrl_q.zero && step.step && !step.up && count_q == '0) |=> (&count_q))
		else $error("Down count did not wrap");
	strobe_self_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(ctrl_q.zero || ctrl_q.capture) |=> !(ctrl_q.zero || ctrl_q.capture))
		else $error("Strobe did not self clear");
	run_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!(wr_fire && aw_addr_q == qcl_pkg::QCL_ADDR_RUN) |=> $stable(ctrl_q.run))
		else $error("Run bit changed without write");
	latch_read_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(s_axi_arvalid && arready_q && s_axi_araddr == qcl_pkg::QCL_ADDR_CAPTURED)
		|=> (rvalid_q && rdata_q == 32'($past(captured_q))))
		else $error("Captured count read wrong");
	write_resp_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(wr_fire && aw_addr_q == qcl_pkg::QCL_ADDR_RUN) |=> (bvalid_q && bresp_q == 2'h0))
		else $error("Mapped write not answered OKAY");
endmodule // qcl_top
`default_nettype wire

/* dv/qcl_enc_model.sv */
`default_nettype none
// ****************************************
// Encoder partner
// ****************************************
module qcl_enc_model (
	output var logic enc_a,
	output var logic enc_b,
	input wire logic clk_sys
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_q = 2'h0;
	initial begin
		enc_a = 1'b0;
		enc_b = 1'b0;
	end
	// Gray walk, A leads B when moving up, pins held 4 cycles
	task automatic move(input int n, input bit up);
		logic [1:0] p;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			p = up ? phase_q + 2'h1 : phase_q - 2'h1;
			phase_q <= p;
			enc_a <= p[1] ^ p[0];
			enc_b <= p[1];
			repeat (3) @(posedge clk_sys);
		end
		repeat (6) @(posedge clk_sys);
	endtask
endmodule // qcl_enc_model
`default_nettype wire

/* dv/quadrature_counter_latch_tb.sv */
`default_nettype none
module quadrature_counter_latch_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] ADDR_NONE = 32'h20400100;
	logic clk_sys, rst_b, enc_a, enc_b;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	logic [31:0] rd_last = 32'h00000000;
	logic [3:0] wr_lanes = 4'hf;
	// ****************************************
	// Instances
	// ****************************************
	qcl_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .enc_a(enc_a), .enc_b(enc_b),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	qcl_enc_model enc_u (.enc_a(enc_a), .enc_b(enc_b), .clk_sys(clk_sys));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t resp got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		bit done;
		done = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= wr_lanes;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid) begin
				chk_resp(s_axi_bresp, er);
				s_axi_bready <= 1'b0;
				done = 1;
			end
		end
	endtask
	task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit done;
		done = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rready && s_axi_rvalid) begin
				chk_resp(s_axi_rresp, er);
				chk_word(s_axi_rdata, ed);
				rd_last = s_axi_rdata;
				s_axi_rready <= 1'b0;
				done = 1;
			end
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		axi_wr(a, d, qcl_pkg::QCL_RESP_OKAY);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] ed);
		axi_rd(a, ed, qcl_pkg::QCL_RESP_OKAY);
	endtask
	// Capture then read, as software does for a live count
	task automatic snap(input logic [31:0] ed);
		wr(qcl_pkg::QCL_ADDR_CAPTURE, 32'h00000001);
		rd(qcl_pkg::QCL_ADDR_CAPTURED, ed);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rd(qcl_pkg::QCL_ADDR_CAPTURED, 32'h00000000);
		rd(qcl_pkg::QCL_ADDR_RUN, 32'h00000000);
		rd(qcl_pkg::QCL_ADDR_ZERO, 32'h00000000);
		rd(qcl_pkg::QCL_ADDR_CAPTURE, 32'h00000000);
		axi_rd(ADDR_NONE, 32'h00000000, qcl_pkg::QCL_RESP_SLVERR);
		axi_wr(ADDR_NONE, 32'h00000001, qcl_pkg::QCL_RESP_SLVERR);
		$display("test reset done");
	endtask
	task automatic t_run_gate();
		enc_u.move(4, 1'b1);
		snap(32'h00000000);
		wr(qcl_pkg::QCL_ADDR_RUN, 32'h00000001);
		rd(qcl_pkg::QCL_ADDR_RUN, 32'h00000001);
		enc_u.move(5, 1'b1);
		snap(32'h00000005);
		$display("test run gate done");
	endtask
	task automatic t_wrap();
		logic [31:0] diff;
		logic [31:0] old_v;
		wr(qcl_pkg::QCL_ADDR_ZERO, 32'h00000001);
		snap(32'h00000000);
		old_v = rd_last;
		enc_u.move(3, 1'b0);
		snap(32'hfffffffd);
		diff = rd_last - old_v;
		chk_word({31'h00000000, diff[31]}, 32'h00000001);
		$display("test wrap done");
	endtask
	task automatic t_zero_writes();
		wr(qcl_pkg::QCL_ADDR_ZERO, 32'h00000000);
		wr(qcl_pkg::QCL_ADDR_CAPTURE, 32'h00000000);
		enc_u.move(2, 1'b1);
		rd(qcl_pkg::QCL_ADDR_CAPTURED, 32'hfffffffd);
		snap(32'hffffffff);
		wr(qcl_pkg::QCL_ADDR_CAPTURED, 32'h12345678);
		rd(qcl_pkg::QCL_ADDR_CAPTURED, 32'hffffffff);
		enc_u.move(1, 1'b1);
		snap(32'h00000000);
		rd(qcl_pkg::QCL_ADDR_ZERO, 32'h00000000);
		rd(qcl_pkg::QCL_ADDR_CAPTURE, 32'h00000000);
		rd(qcl_pkg::QCL_ADDR_RUN, 32'h00000001);
		$display("test strobe zero writes done");
	endtask
	task automatic t_stop();
		wr_lanes = 4'he;
		wr(qcl_pkg::QCL_ADDR_RUN, 32'h00000000);
		wr_lanes = 4'hf;
		rd(qcl_pkg::QCL_ADDR_RUN, 32'h00000001);
		wr(qcl_pkg::QCL_ADDR_RUN, 32'h00000000);
		rd(qcl_pkg::QCL_ADDR_RUN, 32'h00000000);
		enc_u.move(3, 1'b1);
		snap(32'h00000000);
		$display("test stop done");
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_b = 1'b0;
		s_axi_awaddr = 32'h00000000;
		s_axi_wdata = 32'h00000000;
		s_axi_araddr = 32'h00000000;
		s_axi_wstrb = 4'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset();
		t_run_gate();
		t_wrap();
		t_zero_writes();
		t_stop();
		report_and_stop();
	end
endmodule // quadrature_counter_latch_tb
`default_nettype wire
